/* gcr_pkg.sv */
// constants and carrier types of the global control register block
package gcr_pkg;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] GCR_OFS_ID = 8'h00;
  localparam logic [7:0] GCR_OFS_MODE = 8'h02;
  localparam logic [7:0] GCR_OFS_REF = 8'h04;
  localparam logic [7:0] GCR_OFS_PIN = 8'h0a;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int GCR_B_ALLWR = 15;
  localparam int GCR_B_IRQIDLE = 14;
  localparam int GCR_B_ERRTRIG = 7;
  localparam int GCR_B_MEIS = 6;
  localparam int GCR_B_PMM = 4;
  localparam int GCR_B_UPDREQ = 3;
  localparam int GCR_B_LCR = 2;
  localparam int GCR_B_DPR = 1;
  localparam int GCR_B_RST = 0;
  localparam int GCR_B_SRC = 10;
  localparam int GCR_B_OSEL = 9;
  localparam int GCR_B_ISEL = 8;
  localparam int GCR_B_ADAPT = 0;

  // ************************************************************
  // writable masks and reset values
  // ************************************************************
  localparam logic [15:0] GCR_MASK_MODE = 16'hc0ff;
  localparam logic [15:0] GCR_MASK_REF = 16'h1f0f;
  localparam logic [15:0] GCR_MASK_PIN = 16'hffff;
  localparam logic [15:0] GCR_RST_MODE = 16'h0002;
  localparam logic [15:0] GCR_RST_REF = 16'h0000;
  localparam logic [15:0] GCR_RST_PIN = 16'h0000;

  // ************************************************************
  // encodings
  // ************************************************************
  localparam logic [1:0] GCR_PMM_PIN = 2'h1;
  localparam logic [1:0] GCR_FN_IN = 2'h0;
  localparam logic [1:0] GCR_FN_STAT = 2'h1;
  localparam logic [1:0] GCR_FN_LO = 2'h2;
  localparam logic [1:0] GCR_FN_HI = 2'h3;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int GCR_CLK_PS = 10000;
  localparam int GCR_RST_MIN_NS = 100;
  localparam int GCR_RST_MIN_CYC =
    (GCR_RST_MIN_NS * 1000 + GCR_CLK_PS - 1) / GCR_CLK_PS;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] addr;
    logic [15:0] data;
    logic [7:0] gpio;
  } gcr_pins_s;

  localparam gcr_pins_s GCR_PINS_IDLE = '{1'b1, 1'b1, 1'b1, 8'h00,
                                          16'h0000, 8'h00};

  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] refc;
    logic [15:0] pin;
    logic [15:0] rdata;
    logic rd_drv;
    logic wr_n_d;
    logic err_d;
    logic pm_d;
    logic done;
    logic err_pulse;
    logic pm_pulse;
    logic ref_out;
    logic ref_in;
  } gcr_state_s;

  function automatic logic gcr_hit(input logic [7:0] a,
                                   input logic [7:0] ofs);
    gcr_hit = (a == ofs);
  endfunction

endpackage

/* gcr_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module gcr_sync3
  import gcr_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // a bit changes only once stages two and three agree
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      s1 <= IDLE;
      s2 <= IDLE;
      s3 <= IDLE;
      q_o <= IDLE;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          q_o[i] <= s3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* gcr_pin_cell.sv */
// one general-purpose pin: function select with overrides
`timescale 1ns/1ps
`default_nettype none
module gcr_pin_cell
  import gcr_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // control
  input wire logic [1:0] fn_i,
  input wire logic force_in_i,
  input wire logic force_out_i,
  input wire logic force_val_i,
  input wire logic stat_i,
  // pin
  output logic pin_o,
  output logic pin_oe_n_o
);
  logic next_pin;
  logic next_oe_n;

  always_comb begin
    next_pin = 1'b0;
    next_oe_n = 1'b0;
    if (force_in_i) begin
      next_oe_n = 1'b1;
    end else if (force_out_i) begin
      next_pin = force_val_i;
    end else begin
      case (fn_i)
        GCR_FN_IN: next_oe_n = 1'b1;
        GCR_FN_STAT: next_pin = stat_i;
        GCR_FN_LO: next_pin = 1'b0;
        GCR_FN_HI: next_pin = 1'b1;
        default: next_oe_n = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end else begin
      pin_o <= next_pin;
      pin_oe_n_o <= next_oe_n;
    end
  end
endmodule
`default_nettype wire

/* gcr_top.sv */
// global control and identification registers
`timescale 1ns/1ps
`default_nettype none
module gcr_top
  import gcr_pkg::*;
#(
  // arbitrary identity values
  parameter logic [3:0] REVISION = 4'h1,
  parameter logic [11:0] DEVICE_CODE = 12'h0a5
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // host parallel interface pins
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_oe_n_o,
  // port register write steering
  input wire logic [3:0] port_wr_req_i,
  output logic [3:0] port_wr_en_o,
  output logic port_rd_undef_o,
  // interrupt pin
  input wire logic irq_active_i,
  output logic irq_pin_o,
  output logic irq_pin_oe_n_o,
  // error insertion and performance monitor
  output logic err_insert_o,
  input wire logic one_sec_i,
  input wire logic ports_done_i,
  output logic pm_update_o,
  output logic pm_update_done_o,
  output logic latched_clear_on_read_o,
  // resets to the ports
  output logic datapath_reset_o,
  output logic soft_reset_o,
  // 8 kHz reference and clock adapter
  input wire logic [7:0] ref8k_cand_i,
  output logic ref8k_out_signal_o,
  output logic ref8k_in_signal_o,
  output logic [3:0] clock_adapter_mode_o,
  // port status sources and general-purpose pins
  input wire logic [3:0] port_stat_a_i,
  input wire logic [3:0] port_stat_b_i,
  input wire logic [7:0] gpio_i,
  output logic [7:0] gpio_o,
  output logic [7:0] gpio_oe_n_o
);

  // ************************************************************
  // pin synchronisation
  // ************************************************************
  gcr_pins_s raw;
  gcr_pins_s pins;

  assign raw = '{cs_n_i, rd_n_i, wr_n_i, addr_i, data_i, gpio_i};

  gcr_sync3 #(
    .W($bits(gcr_pins_s)),
    .IDLE(GCR_PINS_IDLE)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .d_i(raw),
    .q_o(pins)
  );

  // ************************************************************
  // state
  // ************************************************************
  gcr_state_s st;
  gcr_state_s next_st;
  logic wr_take;
  logic err_lvl;
  logic req_lvl;
  logic [1:0] pm_mode;
  logic [7:0] force_in;
  logic [7:0] force_out;
  logic ref_glob;

  assign pm_mode = st.mode[GCR_B_PMM +: 2];
  // write taken at the rising edge of the write strobe
  assign wr_take = pins.wr_n & ~st.wr_n_d & ~pins.cs_n;
  assign err_lvl = st.mode[GCR_B_MEIS] ? pins.gpio[5]
                                       : st.mode[GCR_B_ERRTRIG];
  always_comb begin
    if (pm_mode[1]) begin
      req_lvl = one_sec_i;
    end else if (pm_mode[0]) begin
      req_lvl = pins.gpio[7];
    end else begin
      req_lvl = st.mode[GCR_B_UPDREQ];
    end
  end
  assign ref_glob = st.refc[GCR_B_ISEL] ? pins.gpio[3]
                  : ref8k_cand_i[st.refc[GCR_B_SRC +: 3]];

  always_comb begin
    next_st = st;
    next_st.wr_n_d = pins.wr_n;
    if (wr_take) begin
      if (gcr_hit(pins.addr, GCR_OFS_MODE)) begin
        next_st.mode = pins.data & GCR_MASK_MODE;
      end
      if (gcr_hit(pins.addr, GCR_OFS_REF)) begin
        next_st.refc = pins.data & GCR_MASK_REF;
      end
      if (gcr_hit(pins.addr, GCR_OFS_PIN)) begin
        next_st.pin = pins.data & GCR_MASK_PIN;
      end
    end
    next_st.rd_drv = ~pins.cs_n & ~pins.rd_n;
    if (gcr_hit(pins.addr, GCR_OFS_ID)) begin
      next_st.rdata = {REVISION, DEVICE_CODE};
    end else if (gcr_hit(pins.addr, GCR_OFS_MODE)) begin
      next_st.rdata = st.mode;
    end else if (gcr_hit(pins.addr, GCR_OFS_REF)) begin
      next_st.rdata = st.refc;
    end else if (gcr_hit(pins.addr, GCR_OFS_PIN)) begin
      next_st.rdata = st.pin;
    end else begin
      next_st.rdata = 16'h0000;
    end
    // error insertion on the rising edge of the selected source
    next_st.err_d = err_lvl;
    next_st.err_pulse = err_lvl & ~st.err_d;
    // update pulse loads registers and clears counters
    next_st.pm_d = req_lvl;
    next_st.pm_pulse = req_lvl & ~st.pm_d;
    // done sets while requested, clears once the request drops
    next_st.done = req_lvl & (st.done | ports_done_i);
    next_st.ref_out = ref_glob;
    next_st.ref_in = st.refc[GCR_B_ISEL] & pins.gpio[3];
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st <= '0;
      st.mode <= GCR_RST_MODE;
      st.refc <= GCR_RST_REF;
      st.pin <= GCR_RST_PIN;
      st.wr_n_d <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign data_o = st.rdata;
  assign data_oe_n_o = ~st.rd_drv;
  assign port_wr_en_o = st.mode[GCR_B_ALLWR] ? {4{|port_wr_req_i}}
                                             : port_wr_req_i;
  assign port_rd_undef_o = st.mode[GCR_B_ALLWR];
  assign irq_pin_o = ~irq_active_i;
  assign irq_pin_oe_n_o = ~irq_active_i & ~st.mode[GCR_B_IRQIDLE];
  assign err_insert_o = st.err_pulse;
  assign pm_update_o = st.pm_pulse;
  assign pm_update_done_o = st.done;
  assign latched_clear_on_read_o = st.mode[GCR_B_LCR];
  assign datapath_reset_o = st.mode[GCR_B_DPR];
  assign soft_reset_o = st.mode[GCR_B_RST];
  assign ref8k_out_signal_o = st.ref_out;
  assign ref8k_in_signal_o = st.ref_in;
  assign clock_adapter_mode_o = st.refc[GCR_B_ADAPT +: 4];

  // ************************************************************
  // general-purpose pins
  // ************************************************************
  always_comb begin
    force_in = 8'h00;
    force_out = 8'h00;
    force_in[7] = (pm_mode == GCR_PMM_PIN);
    force_in[5] = st.mode[GCR_B_MEIS];
    force_in[3] = st.refc[GCR_B_ISEL];
    force_out[1] = st.refc[GCR_B_OSEL];
  end

  for (genvar k = 0; k < 8; k++) begin : g_pin
    gcr_pin_cell u_cell (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .fn_i(st.pin[2*k +: 2]),
      .force_in_i(force_in[k]),
      .force_out_i(force_out[k]),
      .force_val_i(st.ref_out),
      .stat_i((k % 2 == 1) ? port_stat_b_i[k/2]
                           : port_stat_a_i[k/2]),
      .pin_o(gpio_o[k]),
      .pin_oe_n_o(gpio_oe_n_o[k])
    );
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  // source select held steady, so the edge belongs to one source
  sequence s_trig_rise;
    !st.mode[GCR_B_MEIS] && $stable(st.mode[GCR_B_MEIS]) &&
    $rose(st.mode[GCR_B_ERRTRIG]);
  endsequence

  sequence s_req_rise;
    pm_mode == 2'h0 && $stable(pm_mode) &&
    $rose(st.mode[GCR_B_UPDREQ]);
  endsequence

  sequence s_pin6_rise;
    st.mode[GCR_B_MEIS] && $stable(st.mode[GCR_B_MEIS]) &&
    $rose(pins.gpio[5]);
  endsequence

  sequence s_pin8_rise;
    pm_mode == GCR_PMM_PIN && $stable(pm_mode) && $rose(pins.gpio[7]);
  endsequence

  sequence s_tick_rise;
    pm_mode[1] && $stable(pm_mode) && $rose(one_sec_i);
  endsequence

  sequence s_id_read;
    !pins.cs_n && !pins.rd_n && gcr_hit(pins.addr, GCR_OFS_ID);
  endsequence

  a_bcast_write: assert property (
    st.mode[GCR_B_ALLWR] && |port_wr_req_i |-> port_wr_en_o == 4'hf)
    else $error("port write not copied to all ports");
  a_irq_drive: assert property (
    irq_active_i ? (!irq_pin_o && !irq_pin_oe_n_o)
                 : (irq_pin_o && irq_pin_oe_n_o == !st.mode[GCR_B_IRQIDLE]))
    else $error("interrupt pin level wrong");
  a_err_insert: assert property (
    s_trig_rise |=> err_insert_o ##1 !err_insert_o)
    else $error("manual error not inserted once");
  a_err_pin: assert property (
    s_pin6_rise |=> err_insert_o)
    else $error("pin 6 edge did not insert error");
  a_pm_update: assert property (
    s_req_rise |=> pm_update_o)
    else $error("update pulse missing");
  a_pm_pin: assert property (
    s_pin8_rise |=> pm_update_o)
    else $error("pin 8 edge did not update");
  a_pm_tick: assert property (
    s_tick_rise |=> pm_update_o)
    else $error("one-second tick did not update");
  a_done_set: assert property (
    req_lvl && ports_done_i |=> pm_update_done_o)
    else $error("done not set while requested");
  a_done_clear: assert property (
    !req_lvl |=> !pm_update_done_o)
    else $error("done stays with request low");
  a_dpr_reset: assert property (
    $rose(resetn_i) |-> datapath_reset_o && !soft_reset_o)
    else $error("reset bits wrong after reset");
  a_ref_src: assert property (
    !st.refc[GCR_B_ISEL] |=>
      ref8k_out_signal_o == $past(ref8k_cand_i[st.refc[GCR_B_SRC +: 3]]))
    else $error("8 kHz source not followed");
  a_ref_pin4: assert property (
    st.refc[GCR_B_ISEL] |=> ref8k_out_signal_o == $past(pins.gpio[3]))
    else $error("8 kHz source field not ignored");
  a_ref_in_low: assert property (
    !st.refc[GCR_B_ISEL] |=> !ref8k_in_signal_o)
    else $error("8 kHz input not forced low");
  a_pin2_ref: assert property (
    st.refc[GCR_B_OSEL] [*2] |->
      !gpio_oe_n_o[1] && gpio_o[1] == $past(ref8k_out_signal_o))
    else $error("pin 2 not carrying 8 kHz reference");
  a_pin4_input: assert property (
    st.refc[GCR_B_ISEL] [*2] |-> gpio_oe_n_o[3])
    else $error("pin 4 driven while 8 kHz input");
  a_id_read: assert property (
    s_id_read |=> !data_oe_n_o && data_o == {REVISION, DEVICE_CODE})
    else $error("identity read wrong");
  a_mode_reserved: assert property (
    !data_oe_n_o && $past(gcr_hit(pins.addr, GCR_OFS_MODE)) |->
      (data_o & ~GCR_MASK_MODE) == 16'h0000)
    else $error("reserved mode bits read nonzero");
  a_pin8_input: assert property (
    (pm_mode == GCR_PMM_PIN) [*2] |-> gpio_oe_n_o[7])
    else $error("pin 8 driven in pin update mode");
  a_pin6_input: assert property (
    st.mode[GCR_B_MEIS] [*2] |-> gpio_oe_n_o[5])
    else $error("pin 6 driven while error source");

endmodule
`default_nettype wire

/* gcr_host_model.sv */
// host processor model driving the parallel register pins
`timescale 1ns/1ps
`default_nettype none
module gcr_host_model
  import gcr_pkg::*;
(
  // clock
  input wire logic core_clk_i,
  // device read side
  input wire logic [15:0] dev_data_i,
  input wire logic dev_oe_n_i,
  // strobes and shared data bus
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [7:0] addr_o,
  output logic [15:0] bus_o
);
  logic [15:0] hdata = 16'h0000;
  logic hdrv = 1'b0;
  logic [15:0] pat = 16'h5a5a;

  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 8'h00;
  end

  // released bus shows a changing pattern, not the last value
  always @(posedge core_clk_i) pat <= ~pat;
  assign bus_o = !dev_oe_n_i ? dev_data_i : (hdrv ? hdata : pat);

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // ****
  // bus cycles, spaced so a reset bit always stands over 100 ns
  // ****
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    step(1);
    addr_o = a;
    hdata = d;
    hdrv = 1'b1;
    cs_n_o = 1'b0;
    wr_n_o = 1'b0;
    step(6);
    wr_n_o = 1'b1;
    step(6);
    cs_n_o = 1'b1;
    hdrv = 1'b0;
    step(8);
  endtask

  task automatic read(input logic [7:0] a, output logic [15:0] d,
                      output bit ok);
    int i;
    step(1);
    addr_o = a;
    cs_n_o = 1'b0;
    rd_n_o = 1'b0;
    ok = 1'b0;
    for (i = 0; i < 20 && !ok; i++) begin
      step(1);
      ok = (dev_oe_n_i === 1'b0);
    end
    step(2);
    d = bus_o;
    rd_n_o = 1'b1;
    cs_n_o = 1'b1;
    step(8);
  endtask
endmodule
`default_nettype wire

/* gcr_tb_top.sv */
// self-checking bench of the global control register block
`timescale 1ns/1ps
`default_nettype none
module gcr_tb_top
  import gcr_pkg::*;
;
  // arbitrary identity values
  localparam logic [3:0] T_REV = 4'h6;
  localparam logic [11:0] T_CODE = 12'h3c2;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cs_n, rd_n, wr_n, oe_n, irq_act, irq_pin, irq_oe_n, err;
  logic one_sec, done_in, pm_update_request, pmd, rd_undef, lcr, dpr, srst, rout, rin;
  logic [7:0] addr, cand, gi, go, goe;
  logic [15:0] bus, dout, sm, sr, sp, w, d;
  logic [3:0] req, wr_en, clad, sa, sb;
  logic [1:0] e;
  int fails = 0;
  int n_compared = 0;
  int n_err = 0;
  int n_pm = 0;
  int seed, e0, i, k;
  bit ok;

  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (err === 1'b1) n_err++;
    if (pm_update_request === 1'b1) n_pm++;
  end

  gcr_host_model host (.core_clk_i(clk), .dev_data_i(dout),
    .dev_oe_n_i(oe_n), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .addr_o(addr), .bus_o(bus));
  gcr_top #(.REVISION(T_REV), .DEVICE_CODE(T_CODE)) dut (
    .core_clk_i(clk), .resetn_i(rstn), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .addr_i(addr), .data_i(bus), .data_o(dout),
    .data_oe_n_o(oe_n), .port_wr_req_i(req), .port_wr_en_o(wr_en),
    .port_rd_undef_o(rd_undef), .irq_active_i(irq_act),
    .irq_pin_o(irq_pin), .irq_pin_oe_n_o(irq_oe_n), .err_insert_o(err),
    .one_sec_i(one_sec), .ports_done_i(done_in), .pm_update_o(pm_update_request),
    .pm_update_done_o(pmd), .latched_clear_on_read_o(lcr),
    .datapath_reset_o(dpr), .soft_reset_o(srst), .ref8k_cand_i(cand),
    .ref8k_out_signal_o(rout), .ref8k_in_signal_o(rin),
    .clock_adapter_mode_o(clad), .port_stat_a_i(sa), .port_stat_b_i(sb),
    .gpio_i(gi), .gpio_o(go), .gpio_oe_n_o(goe));

  task automatic stp(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up;
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    host.read(a, d, ok);
    if (!ok) begin
      fails++;
      wrap_up();
    end else begin
      chk($sformatf("reg %h", a), d, exp);
    end
  endtask

  task automatic wm(input logic [15:0] v);
    sm = v & 16'hc0ff;
    host.write(GCR_OFS_MODE, v);
  endtask

  // expected {oe_n, value} of pin k+1
  function automatic logic [1:0] pexp(input int k);
    logic [1:0] f;
    logic st;
    f = sp[2*k+:2];
    st = k[0] ? sb[k/2] : sa[k/2];
    if (k == 1 && sr[9]) return {1'b0, sr[8] ? gi[3] : cand[sr[12:10]]};
    if ((k == 3 && sr[8]) || (k == 5 && sm[6]) ||
        (k == 7 && sm[5:4] == 2'h1)) f = 2'h0;
    case (f)
      2'h0: return 2'b10;
      2'h1: return {1'b0, st};
      2'h2: return 2'b00;
      default: return 2'b01;
    endcase
  endfunction

  initial begin
    #200000;
    fails++;
    wrap_up();
  end

  initial begin
    seed = 32'h3113;
    req = 4'h0;
    irq_act = 1'b0;
    one_sec = 1'b0;
    done_in = 1'b0;
    cand = 8'h00;
    sa = 4'h0;
    sb = 4'h0;
    gi = 8'h00;
    sr = 16'h0000;
    sp = 16'h0000;
    stp(4);
    rstn = 1'b1;
    // ****
    // reset state, identity, unmapped place
    // ****
    chk("dp_reset", dpr, 1'b1);
    rchk(GCR_OFS_ID, {T_REV, T_CODE});
    rchk(GCR_OFS_MODE, 16'h0002);
    rchk(GCR_OFS_REF, 16'h0000);
    rchk(GCR_OFS_PIN, 16'h0000);
    host.write(GCR_OFS_ID, 16'hffff);
    rchk(GCR_OFS_ID, {T_REV, T_CODE});
    host.write(8'h06, 16'hffff);
    rchk(8'h06, 16'h0000);
    for (i = 0; i < 6; i++) begin
      cand = $random(seed);
      gi = $random(seed);
      sa = $random(seed);
      sb = $random(seed);
      w = (i == 0) ? 16'hffff : $random(seed);
      wm(w);
      rchk(GCR_OFS_MODE, sm);
      w = (i == 0) ? 16'hffff : $random(seed);
      sr = w & 16'h1f0f;
      host.write(GCR_OFS_REF, w);
      rchk(GCR_OFS_REF, sr);
      sp = (i == 1) ? 16'h0000 : $random(seed);
      host.write(GCR_OFS_PIN, sp);
      rchk(GCR_OFS_PIN, sp);
      chk("undef", rd_undef, sm[15]);
      chk("clr_rd", lcr, sm[2]);
      chk("resets", {dpr, srst}, sm[1:0]);
      chk("clad", clad, sr[3:0]);
      for (k = 0; k < 8; k++) begin
        e = pexp(k);
        chk("pin_oe_n", goe[k], e[1]);
        if (!e[1]) chk("pin_val", go[k], e[0]);
      end
      chk("ref_out", rout, sr[8] ? gi[3] : cand[sr[12:10]]);
      chk("ref_in", rin, gi[3] & sr[8]);
      irq_act = $random(seed);
      req = (i == 5) ? 4'h0 : 4'h1 << i[1:0];
      stp(1);
      chk("irq_oe_n", irq_oe_n, irq_act ? 1'b0 : !sm[14]);
      if (irq_act || sm[14]) chk("irq_pin", irq_pin, !irq_act);
      chk("wr_en", wr_en, (sm[15] && req != 0) ? 4'hf : req);
    end
    // ****
    // error insertion and update sources
    // ****
    gi = 8'h00;
    wm(16'h0000);
    e0 = n_err;
    wm(16'h0080);
    chk("err_sw", n_err - e0, 1);
    wm(16'h0040);
    e0 = n_err;
    wm(16'h00c0);
    gi[5] = 1'b1;
    stp(10);
    chk("err_pin", n_err - e0, 1);
    e0 = n_pm;
    wm(16'h0008);
    chk("pm_sw", n_pm - e0, 1);
    chk("pm_done", pmd, 1'b0);
    done_in = 1'b1;
    stp(3);
    done_in = 1'b0;
    stp(3);
    chk("pm_done", pmd, 1'b1);
    wm(16'h0000);
    chk("pm_done", pmd, 1'b0);
    e0 = n_pm;
    wm(16'h0010);
    gi[7] = 1'b1;
    stp(10);
    chk("pm_pin", n_pm - e0, 1);
    e0 = n_pm;
    wm(16'h0020);
    gi[7] = 1'b0;
    stp(8);
    gi[7] = 1'b1;
    one_sec = 1'b1;
    stp(1);
    one_sec = 1'b0;
    stp(10);
    chk("pm_tick", n_pm - e0, 1);
    wrap_up();
  end
endmodule
`default_nettype wire
